// file: pdp_pin_model.sv
`timescale 1ns/1ps
module pdp_pin_model (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pin
);
  // driven bits show the port, released bits the outside level
  assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule

// file: pdp_pin_mux.sv
`timescale 1ns/1ps
module pdp_pin_mux (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_latch,
  input wire logic [7:0] i_direction,
  input wire pdp_pkg::pdp_override_type i_override,
  output logic [7:0] o_out,
  output logic [7:0] o_oe
);

  wire logic [7:0] next_out;
  wire logic [7:0] next_oe;

  // owner bits bypass both latch and direction
  assign next_out = (i_override.own & i_override.value) | (~i_override.own & i_latch);
  assign next_oe = (i_override.own & i_override.drive) | (~i_override.own & ~i_direction);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_out <= 8'h00;
      o_oe <= 8'h00;
    end else begin
      o_out <= next_out;
      o_oe <= next_oe;
    end
  end

endmodule

// file: pdp_pkg.sv
package pdp_pkg;

  localparam int unsigned PDP_WIDTH = 8;
  localparam int unsigned PDP_ADDR_WIDTH = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] PDP_IDX_SECOND_PORT_DATA = 8'h08;
  localparam logic [7:0] PDP_IDX_FIRST_PORT_DIRECTION = 8'h87;
  localparam logic [7:0] PDP_IDX_SECOND_PORT_DIRECTION = 8'h88;
  localparam logic [7:0] PDP_IDX_COMPARATOR_CONTROL = 8'h90;
  localparam logic [7:0] PDP_IDX_MISC_CONTROL = 8'h91;
  localparam logic [7:0] PDP_IDX_SECOND_PORT_BIT_OP = 8'h92;

  // field positions
  localparam int unsigned PDP_CMP_A_OE_BIT = 1;
  localparam int unsigned PDP_CMP_B_OE_BIT = 5;
  localparam int unsigned PDP_ALT_SEL_BIT = 0;
  localparam int unsigned PDP_ANALOG_LSB = 4;
  localparam int unsigned PDP_BITOP_SET_BIT = 3;

  // reset values
  localparam logic [7:0] PDP_DIR_RESET = 8'hff;
  localparam logic [7:0] PDP_DATA_RESET = 8'h00;
  localparam logic [7:0] PDP_CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] own;
    logic [7:0] value;
    logic [7:0] drive;
  } pdp_override_type;

  function automatic logic pdp_reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    pdp_reg_hit = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == idx);
  endfunction

endpackage

// file: pdp_port_ctrl.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pdp_port_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_first_port_pin,
  input wire logic [7:0] i_first_port_latch,
  output logic [7:0] o_first_port_out,
  output logic [7:0] o_first_port_oe,
  input wire logic [7:0] i_second_port_pin,
  output logic [7:0] o_second_port_out,
  output logic [7:0] o_second_port_oe,
  output logic [1:0] o_second_port_pullup_off,
  input wire logic i_serial_enable,
  input wire logic i_serial_data_drive_low,
  input wire logic i_serial_clock_drive_low,
  output logic o_serial_data_in,
  output logic o_serial_clock_in,
  input wire logic i_reference_a_output,
  input wire logic i_comparator_a_pin,
  input wire logic i_reference_b_output,
  input wire logic i_comparator_b_pin
);

  logic [7:0] second_port_data;
  logic [7:0] first_port_direction;
  logic [7:0] second_port_direction;
  logic [7:0] comparator_control;
  logic [7:0] misc_control;

  // bus decode
  wire logic access;
  wire logic first_cycle;
  wire logic wr_fire;
  wire logic hit_data;
  wire logic hit_dir_c;
  wire logic hit_dir_d;
  wire logic hit_cmp;
  wire logic hit_misc;
  wire logic hit_bitop;
  wire logic mapped;
  wire logic lane0;

  assign access = i_psel & i_penable;
  assign first_cycle = access & ~o_pready;
  // write lands on the edge where pready is sampled high
  assign wr_fire = access & o_pready & i_pwrite;
  assign lane0 = i_pstrb[0];
  assign hit_data = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_SECOND_PORT_DATA);
  assign hit_dir_c = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_FIRST_PORT_DIRECTION);
  assign hit_dir_d = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_SECOND_PORT_DIRECTION);
  assign hit_cmp = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_COMPARATOR_CONTROL);
  assign hit_misc = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_MISC_CONTROL);
  assign hit_bitop = pdp_pkg::pdp_reg_hit(i_paddr, pdp_pkg::PDP_IDX_SECOND_PORT_BIT_OP);
  assign mapped = hit_data | hit_dir_c | hit_dir_d | hit_cmp | hit_misc | hit_bitop;

  // control decode
  wire logic comparator_a_output_enable;
  wire logic comparator_b_output_enable;
  wire logic alt_select;
  wire logic [3:0] analog_select;
  wire logic sel_c_serial;
  wire logic sel_d_serial;

  assign comparator_a_output_enable = comparator_control[pdp_pkg::PDP_CMP_A_OE_BIT];
  assign comparator_b_output_enable = comparator_control[pdp_pkg::PDP_CMP_B_OE_BIT];
  assign alt_select = misc_control[pdp_pkg::PDP_ALT_SEL_BIT];
  assign analog_select = misc_control[pdp_pkg::PDP_ANALOG_LSB +: 4];
  assign sel_c_serial = i_serial_enable & ~alt_select;
  assign sel_d_serial = i_serial_enable & alt_select;

  // pin read path: analog pins read zero
  wire logic [7:0] second_port_read;
  assign second_port_read = i_second_port_pin & ~{analog_select, 4'h0};

  // read-modify-write: whole byte from pins, one bit changed
  wire logic [2:0] bitop_index;
  wire logic bitop_set;
  wire logic [7:0] bitop_mask;
  wire logic [7:0] bitop_result;

  assign bitop_index = i_pwdata[2:0];
  assign bitop_set = i_pwdata[pdp_pkg::PDP_BITOP_SET_BIT];
  assign bitop_mask = 8'h01 << bitop_index;
  // input pins' latch bits take the sampled pin value
  assign bitop_result = bitop_set ? (second_port_read | bitop_mask) :
                                    (second_port_read & ~bitop_mask);

  // register writes
  wire logic we_data;
  wire logic [7:0] data_d;
  wire logic we_dir_c;
  wire logic we_dir_d;
  wire logic we_cmp;
  wire logic we_misc;

  assign we_data = wr_fire & lane0 & (hit_data | hit_bitop);
  // plain write touches only the latch, never the pins
  assign data_d = hit_bitop ? bitop_result : i_pwdata[7:0];
  assign we_dir_c = wr_fire & lane0 & hit_dir_c;
  assign we_dir_d = wr_fire & lane0 & hit_dir_d;
  assign we_cmp = wr_fire & lane0 & hit_cmp;
  assign we_misc = wr_fire & lane0 & hit_misc;

  // latch value is undefined to software; a fixed reset keeps simulation clean
  pdp_reg8 #(.RESET_VALUE(pdp_pkg::PDP_DATA_RESET)) u_second_port_data (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_data),
    .i_d(data_d),
    .o_q(second_port_data)
  );

  pdp_reg8 #(.RESET_VALUE(pdp_pkg::PDP_DIR_RESET)) u_first_port_direction (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_dir_c),
    .i_d(i_pwdata[7:0]),
    .o_q(first_port_direction)
  );

  pdp_reg8 #(.RESET_VALUE(pdp_pkg::PDP_DIR_RESET)) u_second_port_direction (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_dir_d),
    .i_d(i_pwdata[7:0]),
    .o_q(second_port_direction)
  );

  pdp_reg8 #(.RESET_VALUE(pdp_pkg::PDP_CTRL_RESET)) u_comparator_control (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_cmp),
    .i_d(i_pwdata[7:0]),
    .o_q(comparator_control)
  );

  pdp_reg8 #(.RESET_VALUE(pdp_pkg::PDP_CTRL_RESET)) u_misc_control (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(we_misc),
    .i_d(i_pwdata[7:0]),
    .o_q(misc_control)
  );

  // read mux, sampled in the first access cycle
  wire logic [7:0] read_byte;
  assign read_byte = hit_data ? second_port_read :
                     hit_dir_c ? first_port_direction :
                     hit_dir_d ? second_port_direction :
                     hit_cmp ? comparator_control :
                     hit_misc ? misc_control : 8'h00;

  wire logic next_pready;
  wire logic [31:0] next_prdata;
  wire logic next_pslverr;
  assign next_pready = first_cycle;
  assign next_prdata = (first_cycle & ~i_pwrite) ? {24'h000000, read_byte} : 32'h00000000;
  assign next_pslverr = first_cycle & ~mapped;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= next_pready;
      o_prdata <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  // peripheral ownership; serial lines are open drain, driven only low
  // nets, so each field may take its own assign
  wire pdp_pkg::pdp_override_type first_override;
  wire pdp_pkg::pdp_override_type second_override;

  assign first_override.own = {sel_c_serial, sel_c_serial, 4'h0, comparator_a_output_enable, comparator_a_output_enable};
  assign first_override.value = {6'h00, i_comparator_a_pin, i_reference_a_output};
  assign first_override.drive = {sel_c_serial & i_serial_data_drive_low,
                                 sel_c_serial & i_serial_clock_drive_low,
                                 4'h0, comparator_a_output_enable, comparator_a_output_enable};
  assign second_override.own = {4'h0, comparator_b_output_enable, comparator_b_output_enable, sel_d_serial, sel_d_serial};
  assign second_override.value = {4'h0, i_reference_b_output, i_comparator_b_pin, 2'h0};
  assign second_override.drive = {4'h0, comparator_b_output_enable, comparator_b_output_enable,
                                  sel_d_serial & i_serial_data_drive_low,
                                  sel_d_serial & i_serial_clock_drive_low};

  // first port latch lives outside this block
  pdp_pin_mux u_first_pins (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_latch(i_first_port_latch),
    .i_direction(first_port_direction),
    .i_override(first_override),
    .o_out(o_first_port_out),
    .o_oe(o_first_port_oe)
  );

  pdp_pin_mux u_second_pins (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_latch(second_port_data),
    .i_direction(second_port_direction),
    .i_override(second_override),
    .o_out(o_second_port_out),
    .o_oe(o_second_port_oe)
  );

  // serial inputs idle high like a released bus
  wire logic next_serial_data_in;
  wire logic next_serial_clock_in;
  assign next_serial_data_in = sel_d_serial ? i_second_port_pin[1] :
                               sel_c_serial ? i_first_port_pin[7] : 1'b1;
  assign next_serial_clock_in = sel_d_serial ? i_second_port_pin[0] :
                                sel_c_serial ? i_first_port_pin[6] : 1'b1;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_serial_data_in <= 1'b1;
      o_serial_clock_in <= 1'b1;
      o_second_port_pullup_off <= 2'h0;
    end else begin
      o_serial_data_in <= next_serial_data_in;
      o_serial_clock_in <= next_serial_clock_in;
      o_second_port_pullup_off <= {2{sel_d_serial}};
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_data_write;
    wr_fire && lane0 && hit_data;
  endsequence

  sequence s_bitop_write;
    wr_fire && lane0 && hit_bitop;
  endsequence

  sequence s_read_data;
    first_cycle && !i_pwrite && hit_data;
  endsequence

  sequence s_refused_write;
    wr_fire && (!lane0 || !mapped);
  endsequence

  chk_dir_c_reset: assert property ($fell(i_rst) |-> first_port_direction == 8'hff)
    else $error("first port direction not all ones after reset");
  chk_dir_d_reset: assert property ($fell(i_rst) |-> second_port_direction == 8'hff)
    else $error("second port direction not all ones after reset");
  chk_c_plain_oe: assert property (##1 o_first_port_oe[5:2] == ~$past(first_port_direction[5:2]))
    else $error("first port driver does not follow direction");
  chk_d_plain_oe: assert property (##1 o_second_port_oe[7:4] == ~$past(second_port_direction[7:4]))
    else $error("second port driver does not follow direction");
  chk_cmp_a_own: assert property (comparator_a_output_enable |=> o_first_port_oe[1:0] == 2'h3 &&
      o_first_port_out[1:0] == $past({i_comparator_a_pin, i_reference_a_output}))
    else $error("comparator A pins not driven by comparator and reference");
  chk_cmp_b_own: assert property (comparator_b_output_enable |=> o_second_port_oe[3:2] == 2'h3 &&
      o_second_port_out[3:2] == $past({i_reference_b_output, i_comparator_b_pin}))
    else $error("comparator B pins not driven by reference and comparator");
  chk_serial_c_own: assert property (sel_c_serial |=>
      o_first_port_oe[7:6] == $past({i_serial_data_drive_low, i_serial_clock_drive_low}) &&
      o_first_port_out[7:6] == 2'h0)
    else $error("first port serial pin still follows direction");
  chk_serial_d_own: assert property (sel_d_serial |=>
      o_second_port_pullup_off == 2'h3 && o_second_port_out[1:0] == 2'h0)
    else $error("second port serial pins keep pull-up or latch");
  chk_analog_read: assert property (first_cycle && !i_pwrite && hit_data |=>
      (o_prdata[7:4] & $past(analog_select)) == 4'h0 && o_pready)
    else $error("analog pin does not read zero");
  chk_latch_write: assert property (s_data_write |=> second_port_data == $past(i_pwdata[7:0]))
    else $error("data write did not reach latch");
  chk_bitop_rmw: assert property (s_bitop_write |=> second_port_data == $past(bitop_result))
    else $error("bit operation did not write back pin byte");
  chk_ready_pulse: assert property (first_cycle |=> o_pready ##1 !o_pready)
    else $error("ready not a single cycle answer");

  // nothing refused may disturb any register
  chk_refused_write: assert property (s_refused_write |=> $stable(second_port_data) &&
      $stable(first_port_direction) && $stable(second_port_direction) &&
      $stable(comparator_control) && $stable(misc_control))
    else $error("refused write changed a register");
  chk_data_read: assert property (s_read_data |=>
      o_prdata == {24'h000000, $past(i_second_port_pin) & ~{$past(analog_select), 4'h0}})
    else $error("data read does not return pin levels");
  chk_dir_c_write: assert property (wr_fire && lane0 && hit_dir_c |=>
      first_port_direction == $past(i_pwdata[7:0]))
    else $error("first port direction write lost");
  chk_dir_d_write: assert property (wr_fire && lane0 && hit_dir_d |=>
      second_port_direction == $past(i_pwdata[7:0]))
    else $error("second port direction write lost");
  // sampled reset keeps the attempt at release away from reset outputs
  chk_c_low_pins: assert property (!i_rst && !comparator_a_output_enable |=>
      o_first_port_oe[1:0] == ~$past(first_port_direction[1:0]) &&
      o_first_port_out[1:0] == $past(i_first_port_latch[1:0]))
    else $error("first port low pins ignore direction or latch");
  chk_d_mid_pins: assert property (!i_rst && !comparator_b_output_enable |=>
      o_second_port_oe[3:2] == ~$past(second_port_direction[3:2]) &&
      o_second_port_out[3:2] == $past(second_port_data[3:2]))
    else $error("second port middle pins ignore direction or latch");
  chk_d_low_pins: assert property (!i_rst && !sel_d_serial |=>
      o_second_port_oe[1:0] == ~$past(second_port_direction[1:0]) &&
      o_second_port_out[1:0] == $past(second_port_data[1:0]))
    else $error("second port low pins ignore direction or latch");
  chk_serial_d_drive: assert property (sel_d_serial |=>
      o_second_port_oe[1:0] == $past({i_serial_data_drive_low, i_serial_clock_drive_low}))
    else $error("alternate serial pins not driven by the peripheral");
  chk_route_d: assert property (!i_rst && sel_d_serial |=>
      {o_serial_data_in, o_serial_clock_in} == $past(i_second_port_pin[1:0]))
    else $error("alternate serial pins not routed to the peripheral");
  chk_route_c: assert property (!i_rst && sel_c_serial |=>
      {o_serial_data_in, o_serial_clock_in} == $past(i_first_port_pin[7:6]))
    else $error("first port serial pins not routed to the peripheral");
  chk_serial_idle: assert property (!i_rst && !i_serial_enable |=>
      o_serial_data_in && o_serial_clock_in && o_second_port_pullup_off == 2'h0)
    else $error("serial lines or pull-up not idle while disabled");
  chk_slverr_map: assert property (first_cycle |=> o_pslverr == !$past(mapped))
    else $error("error answer does not match the address map");
  chk_prdata_idle: assert property (!(first_cycle && !i_pwrite) |=>
      o_prdata == 32'h00000000)
    else $error("read data does not return to zero");

endmodule

// file: pdp_reg8.sv
`timescale 1ns/1ps
module pdp_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [7:0] i_d,
  output logic [7:0] o_q
);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RESET_VALUE;
    end else if (i_we) begin
      o_q <= i_d;
    end
  end

endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] A_DATA = {2'h0, pdp_pkg::PDP_IDX_SECOND_PORT_DATA, 2'h0};
  localparam logic [11:0] A_CDIR = {2'h0, pdp_pkg::PDP_IDX_FIRST_PORT_DIRECTION, 2'h0};
  localparam logic [11:0] A_DDIR = {2'h0, pdp_pkg::PDP_IDX_SECOND_PORT_DIRECTION, 2'h0};
  localparam logic [11:0] A_CMP = {2'h0, pdp_pkg::PDP_IDX_COMPARATOR_CONTROL, 2'h0};
  localparam logic [11:0] A_MISC = {2'h0, pdp_pkg::PDP_IDX_MISC_CONTROL, 2'h0};
  localparam logic [11:0] A_BIT = {2'h0, pdp_pkg::PDP_IDX_SECOND_PORT_BIT_OP, 2'h0};
  logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0] i_pstrb;
  logic [7:0] c_pin, c_latch, c_out, c_oe, c_ext, d_pin, d_out, d_oe, d_ext;
  logic [1:0] pu_off;
  logic ser_en, sd_low, sc_low, sd_in, sc_in, ref_a, cmp_a, ref_b, cmp_b;
  int bad_count, checked, cycles;
  // upper byte direction, lower byte data
  logic [15:0] rows [4] = '{16'h00a5, 16'hff3c, 16'h0ff0, 16'h5ac3};

  pdp_port_ctrl DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_first_port_pin(c_pin), .i_first_port_latch(c_latch), .o_first_port_out(c_out),
    .o_first_port_oe(c_oe), .i_second_port_pin(d_pin), .o_second_port_out(d_out),
    .o_second_port_oe(d_oe), .o_second_port_pullup_off(pu_off), .i_serial_enable(ser_en),
    .i_serial_data_drive_low(sd_low), .i_serial_clock_drive_low(sc_low),
    .o_serial_data_in(sd_in), .o_serial_clock_in(sc_in), .i_reference_a_output(ref_a),
    .i_comparator_a_pin(cmp_a), .i_reference_b_output(ref_b), .i_comparator_b_pin(cmp_b));
  pdp_pin_model c_pins (.i_out(c_out), .i_oe(c_oe), .i_ext(c_ext), .o_pin(c_pin));
  pdp_pin_model d_pins (.i_out(d_out), .i_oe(d_oe), .i_ext(d_ext), .o_pin(d_pin));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // outputs are registered, so give a store two edges to reach the pins
  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: pins %h, wanted %h", $time, got, exp);
    end
  endtask

  initial begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    {c_latch, c_ext, d_ext} = {8'h00, 8'h69, 8'h97};
    {ser_en, sd_low, sc_low, ref_a, cmp_a, ref_b, cmp_b} = 7'h00;
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    settle();
    chk_byte(c_oe, 8'h00);
    chk_byte(d_oe, 8'h00);
    apb(1'b0, A_CDIR, 32'h0);
    chk_word(rd, 32'hff);
    apb(1'b0, A_DDIR, 32'h0);
    chk_word(rd, 32'hff);
    foreach (rows[i]) begin
      apb(1'b1, A_DATA, {24'h0, rows[i][7:0]});
      c_latch <= rows[i][7:0];
      apb(1'b1, A_DDIR, {24'h0, rows[i][15:8]});
      apb(1'b1, A_CDIR, {24'h0, rows[i][15:8]});
      settle();
      chk_byte(d_oe, ~rows[i][15:8]);
      chk_byte(d_out & d_oe, rows[i][7:0] & ~rows[i][15:8]);
      chk_byte(c_oe, ~rows[i][15:8]);
      chk_byte(c_out & c_oe, rows[i][7:0] & ~rows[i][15:8]);
      apb(1'b0, A_DATA, 32'h0);
      chk_word(rd, {24'h0, (rows[i][7:0] & ~rows[i][15:8]) | (d_ext & rows[i][15:8])});
    end
    // bit set with inputs present: input bits take the pin level
    apb(1'b1, A_DDIR, 32'h0f);
    apb(1'b1, A_DATA, 32'h05);
    settle();
    apb(1'b1, A_BIT, 32'h0e);
    apb(1'b1, A_DDIR, 32'h00);
    settle();
    chk_byte(d_out, 8'h47);
    apb(1'b1, A_BIT, 32'h02);
    settle();
    chk_byte(d_out, 8'h43);
    apb(1'b1, A_MISC, 32'hf0);
    apb(1'b0, A_DATA, 32'h0);
    chk_word(rd, 32'h03);
    apb(1'b1, A_MISC, 32'h00);
    apb(1'b1, A_DDIR, 32'hff);
    apb(1'b1, A_CDIR, 32'hff);
    apb(1'b1, A_CMP, 32'h22);
    {ref_a, cmp_a, ref_b, cmp_b} <= 4'b1010;
    settle();
    chk_byte(c_oe & 8'h03, 8'h03);
    chk_byte(c_out & 8'h03, 8'h01);
    chk_byte(d_oe & 8'h0c, 8'h0c);
    chk_byte(d_out & 8'h0c, 8'h08);
    apb(1'b1, A_CMP, 32'h00);
    apb(1'b1, A_CDIR, 32'h00);
    {ser_en, sd_low} <= 2'b11;
    settle();
    chk_byte(c_oe & 8'hc0, 8'h80);
    chk_byte(c_out & 8'hc0, 8'h00);
    chk_byte({6'h0, sd_in, sc_in}, 8'h01);
    apb(1'b1, A_MISC, 32'h01);
    settle();
    chk_byte(d_oe & 8'h03, 8'h02);
    chk_byte({6'h0, pu_off}, 8'h03);
    chk_byte({6'h0, sd_in, sc_in}, 8'h01);
    chk_byte(c_oe & 8'hc0, 8'hc0);
    apb(1'b0, A_DATA, 32'h0);
    ser_en <= 1'b0;
    settle();
    chk_byte({6'h0, pu_off}, 8'h00);
    // a write with no byte strobe must leave the register alone
    apb(1'b0, A_DATA, 32'h0);
    i_pstrb <= 4'h0;
    apb(1'b1, A_DDIR, 32'h00);
    i_pstrb <= 4'hf;
    apb(1'b0, A_DDIR, 32'h0);
    chk_word(rd, 32'hff);
    apb(1'b0, 12'h300, 32'h0);
    chk_word({rd[30:0], err}, 32'h1);
    apb(1'b1, A_CDIR, 32'h00);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    apb(1'b0, A_CDIR, 32'h0);
    chk_word(rd, 32'hff);
    stop_test();
  end
endmodule
